// *** pkg/sbp_params.svh ***
// Constants for the status register and block-protection logic.
// Assumes inclusion by bare name from the package and the core module.
`ifndef SBP_PARAMS_SVH
`define SBP_PARAMS_SVH

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define SBP_BIT_SRWD   7
`define SBP_BIT_BP3    6
`define SBP_BIT_TB     5
`define SBP_BIT_BP2    4
`define SBP_BIT_BP0    2
`define SBP_BIT_WEL    1
`define SBP_BIT_WIP    0

// ----------------------------------------------------------------
// Reset values and array geometry
// ----------------------------------------------------------------
`define SBP_SR_RESET    8'h00
`define SBP_ADDR_W      24
`define SBP_ADDR_MAX    24'hffffff
`define SBP_SECT_MSB    23
`define SBP_SECT_LSB    16
`define SBP_SECT_COUNT  9'h100
`define SBP_BP_ALL      4'h9

// ----------------------------------------------------------------
// Busy durations in clk cycles (defaults only)
// ----------------------------------------------------------------
`define SBP_WRSR_CYC    16
`define SBP_PROG_CYC    64
`define SBP_ERASE_CYC   256

`endif

// *** pkg/sbp_pkg.sv ***
// Types shared by the status/protection core and its bench.
// Assumes sbp_params.svh on the include path.
`include "sbp_params.svh"

package sbp_pkg;

    typedef enum logic [2:0] {
        SBP_OP_READ_SR  = 3'h0,
        SBP_OP_WRITE_SR = 3'h1,
        SBP_OP_WR_EN    = 3'h2,
        SBP_OP_WR_DIS   = 3'h3,
        SBP_OP_PROGRAM  = 3'h4,
        SBP_OP_SECT_ER  = 3'h5,
        SBP_OP_SUB_ER   = 3'h6,
        SBP_OP_BULK_ER  = 3'h7
    } sbp_op_t;

    typedef struct packed {
        sbp_op_t                   op;
        logic [`SBP_ADDR_W-1:0]    addr;
        logic [7:0]                wdata;
    } sbp_cmd_t;

    typedef struct packed {
        sbp_op_t                   op;
        logic [`SBP_ADDR_W-1:0]    addr;
    } sbp_array_req_t;

    typedef enum logic [0:0] {
        SBP_ST_IDLE = 1'b0,
        SBP_ST_BUSY = 1'b1
    } sbp_state_t;

endpackage

// *** core/sbp_status_protect.sv ***
// Status register, write-protect pin handling and block-protection decode.
// Assumes a command decoder on clk presents decoded commands one per pulse;
// the write-protect pin arrives asynchronously and is synchronised here.
`timescale 1ns/100ps
`include "sbp_params.svh"

// Summary of operation
// - Read-status returns the register; write-status updates its writable bits.
// - Bit 7 set with write-protect low makes nonvolatile bits read-only.
// - Raising the write-protect pin or a reset (which clears bit 7) leaves hardware protection.
// - Bit 7 is nonvolatile, default 0 enables writes, 1 disables with pin.
// - Bit 5 picks protected origin: 0 top, 1 bottom.
// - Block-protect bits sit at bit 6 (msb) and bits 4 to 2.
// - Value n in 1..8 protects 2^(n-1) sectors; 9..15 all; 0 none.
// - Write-enable latch at bit 1 clears at power-up.
// - Write-enable command sets latch; writes, programs, erases need it.
// - Bit 0 reads 1 during write-status, program or erase, else 0.
// - Bulk erase runs only when all block-protect bits are zero.
// - Bit 0 always equals inverse of program/erase controller ready flag.
// - 24-bit addresses, 256 sectors of 64KB, subsectors of 32KB and 4KB.
module sbp_status_protect
    import sbp_pkg::*;
#(
    parameter int WRSR_CYC  = `SBP_WRSR_CYC,
    parameter int PROG_CYC  = `SBP_PROG_CYC,
    parameter int ERASE_CYC = `SBP_ERASE_CYC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // Write-protect pin, asynchronous
    input  wire logic               wp_n,
    // Decoded commands
    input  wire logic               cmd_valid,
    input  wire sbp_pkg::sbp_cmd_t  cmd,
    // Status read answer
    output logic                    rd_valid,
    output logic [7:0]              rd_data,
    // Array engine request
    output logic                    array_go,
    output sbp_pkg::sbp_array_req_t array_req,
    // Status seen by the rest of the device
    output logic [7:0]              status,
    output logic                    pe_ready,
    output logic                    prot_err,
    output logic                    cmd_refused
);
    import sbp_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchroniser
    // ----------------------------------------------------------------
    logic wp_meta_q;
    logic wp_sync_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_meta_q <= 1'b0;
            wp_sync_q <= 1'b0;
        end else begin
            wp_meta_q <= wp_n;
            wp_sync_q <= wp_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sbp_state_t  state_q, state_d;
    logic        srwd_q, srwd_d;
    logic        tb_q, tb_d;
    logic [3:0]  bp_q, bp_d;
    logic        wel_q, wel_d;
    logic [15:0] busy_cnt_q, busy_cnt_d;
    logic        rd_valid_q, rd_valid_d;
    logic [7:0]  rd_data_q, rd_data_d;
    logic        go_q, go_d;
    sbp_array_req_t req_q, req_d;
    logic        perr_q, perr_d;
    logic        refuse_q, refuse_d;

    // ----------------------------------------------------------------
    // Protection decode
    // ----------------------------------------------------------------
    logic       hw_locked;
    logic [8:0] prot_cnt;
    logic [8:0] sect;
    logic       in_prot;
    logic       wip;

    assign hw_locked = srwd_q && !wp_sync_q;
    assign wip       = (state_q == SBP_ST_BUSY);
    assign sect      = {1'b0, cmd.addr[`SBP_SECT_MSB:`SBP_SECT_LSB]};

    always_comb begin
        if (bp_q == 4'h0) begin
            prot_cnt = 9'h000;
        end else if (bp_q >= `SBP_BP_ALL) begin
            prot_cnt = `SBP_SECT_COUNT;
        end else begin
            prot_cnt = 9'h001 << (bp_q - 4'h1);
        end
    end

    // Top counts down from the last sector, bottom up from sector 0
    assign in_prot = tb_q ? (sect < prot_cnt)
                          : ((sect + prot_cnt) >= `SBP_SECT_COUNT);

    // Bits 6 and 4:2 carry the protect value
    assign status = {srwd_q, bp_q[3], tb_q, bp_q[2:0], wel_q, wip};
    assign pe_ready = !wip;

    // ----------------------------------------------------------------
    // Command handling
    // ----------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        srwd_d     = srwd_q;
        tb_d       = tb_q;
        bp_d       = bp_q;
        wel_d      = wel_q;
        busy_cnt_d = busy_cnt_q;
        rd_valid_d = 1'b0;
        rd_data_d  = rd_data_q;
        go_d       = 1'b0;
        req_d      = req_q;
        perr_d     = 1'b0;
        refuse_d   = 1'b0;

        unique case (state_q)
            SBP_ST_IDLE: begin
                if (cmd_valid) begin
                    unique case (cmd.op)
                        SBP_OP_READ_SR: begin
                            rd_valid_d = 1'b1;
                            rd_data_d  = status;
                        end
                        SBP_OP_WR_EN: begin
                            wel_d = 1'b1;
                        end
                        SBP_OP_WR_DIS: begin
                            wel_d = 1'b0;
                        end
                        SBP_OP_WRITE_SR: begin
                            if (!wel_q || hw_locked) begin
                                refuse_d = 1'b1;
                                wel_d    = 1'b0;
                            end else begin
                                srwd_d     = cmd.wdata[`SBP_BIT_SRWD];
                                tb_d       = cmd.wdata[`SBP_BIT_TB];
                                bp_d       = {cmd.wdata[`SBP_BIT_BP3],
                                              cmd.wdata[`SBP_BIT_BP2:`SBP_BIT_BP0]};
                                busy_cnt_d = 16'(WRSR_CYC);
                                state_d    = SBP_ST_BUSY;
                            end
                        end
                        default: begin
                            // Program and all erases
                            if (!wel_q) begin
                                refuse_d = 1'b1;
                            end else if ((cmd.op == SBP_OP_BULK_ER) ? (bp_q != 4'h0)
                                                                    : in_prot) begin
                                refuse_d = 1'b1;
                                perr_d   = 1'b1;
                                wel_d    = 1'b0;
                            end else begin
                                go_d          = 1'b1;
                                req_d.op      = cmd.op;
                                req_d.addr    = cmd.addr;
                                busy_cnt_d    = 16'((cmd.op == SBP_OP_PROGRAM) ? PROG_CYC
                                                                               : ERASE_CYC);
                                state_d       = SBP_ST_BUSY;
                            end
                        end
                    endcase
                end
            end
            SBP_ST_BUSY: begin
                // Only status reads are served while busy, so software can poll
                if (cmd_valid && cmd.op == SBP_OP_READ_SR) begin
                    rd_valid_d = 1'b1;
                    rd_data_d  = status;
                end else if (cmd_valid) begin
                    refuse_d = 1'b1;
                end
                if (busy_cnt_q <= 16'h0001) begin
                    busy_cnt_d = 16'h0000;
                    wel_d      = 1'b0;
                    state_d    = SBP_ST_IDLE;
                end else begin
                    busy_cnt_d = busy_cnt_q - 16'h0001;
                end
            end
        endcase
    end

    // Nonvolatile bits have no backing store here; power-up gives defaults
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q    <= SBP_ST_IDLE;
            srwd_q     <= 1'b0;
            tb_q       <= 1'b0;
            bp_q       <= 4'h0;
            wel_q      <= 1'b0;
            busy_cnt_q <= 16'h0000;
            rd_valid_q <= 1'b0;
            rd_data_q  <= `SBP_SR_RESET;
            go_q       <= 1'b0;
            req_q      <= '0;
            perr_q     <= 1'b0;
            refuse_q   <= 1'b0;
        end else begin
            state_q    <= state_d;
            srwd_q     <= srwd_d;
            tb_q       <= tb_d;
            bp_q       <= bp_d;
            wel_q      <= wel_d;
            busy_cnt_q <= busy_cnt_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q  <= rd_data_d;
            go_q       <= go_d;
            req_q      <= req_d;
            perr_q     <= perr_d;
            refuse_q   <= refuse_d;
        end
    end

    assign rd_valid    = rd_valid_q;
    assign rd_data     = rd_data_q;
    assign array_go    = go_q;
    assign array_req   = req_q;
    assign prot_err    = perr_q;
    assign cmd_refused = refuse_q;

endmodule // sbp_status_protect

// *** verification/sbp_status_protect_chk.sv ***
// Port-level checks for the status and block-protection core.
// Assumes it is bound to every instance of the core.
`timescale 1ns/100ps
module sbp_status_protect_chk
    import sbp_pkg::*;
#(
    parameter int WRSR_CYC  = 16,
    parameter int PROG_CYC  = 64,
    parameter int ERASE_CYC = 256
) (
    // Clock, reset, pin
    input wire logic                    clk,
    input wire logic                    rstn,
    input wire logic                    wp_n,
    // Command side
    input wire logic                    cmd_valid,
    input wire sbp_pkg::sbp_cmd_t       cmd,
    // Answers
    input wire logic                    rd_valid,
    input wire logic [7:0]              rd_data,
    input wire logic                    array_go,
    input wire sbp_pkg::sbp_array_req_t array_req,
    input wire logic [7:0]              status,
    input wire logic                    pe_ready,
    input wire logic                    prot_err,
    input wire logic                    cmd_refused
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    localparam int WMAX = WRSR_CYC + 2;
    logic [3:0] bp;
    logic       idle_cmd;
    assign bp       = {status[6], status[4:2]};
    assign idle_cmd = cmd_valid && !status[0];

    AST_PE_INV: assert property (pe_ready == !status[0])
        else $error("ready flag not inverse of busy bit");
    AST_RD: assert property (cmd_valid && cmd.op == SBP_OP_READ_SR |=>
        rd_valid && rd_data == $past(status)) else $error("status read wrong");
    AST_WEL: assert property (idle_cmd && cmd.op == SBP_OP_WR_EN |=> status[1])
        else $error("latch not set");
    AST_NOWEL: assert property (idle_cmd && !status[1] && cmd.op >= SBP_OP_PROGRAM
        |=> cmd_refused && !array_go) else $error("op ran without latch");
    AST_BULK: assert property (idle_cmd && status[1] && cmd.op == SBP_OP_BULK_ER
        && bp != 4'h0 |=> prot_err && !array_go) else $error("bulk erase ran");
    AST_BUSY: assert property (cmd_valid && status[0] && cmd.op != SBP_OP_READ_SR
        |=> cmd_refused && !array_go) else $error("command taken while busy");
    AST_GO: assert property (array_go |-> status[0] && !prot_err)
        else $error("accepted op not busy");
    AST_HWP: assert property (idle_cmd && cmd.op == SBP_OP_WRITE_SR && status[7]
        && !wp_n && !$past(wp_n) && !$past(wp_n, 2) |=> cmd_refused && $stable(status[7:2]))
        else $error("locked register written");
    AST_WRSR: assert property (idle_cmd && cmd.op == SBP_OP_WRITE_SR && status[1]
        && !status[7] |=> status[0] ##[1:WMAX] !status[0]) else $error("write busy wrong");

    CV_GO:  cover property (array_go);
    CV_ERR: cover property (prot_err);
    CV_RD:  cover property (rd_valid);
endmodule // sbp_status_protect_chk

bind sbp_status_protect sbp_status_protect_chk #(
    .WRSR_CYC(WRSR_CYC), .PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC)
) u_chk (
    .clk(clk), .rstn(rstn), .wp_n(wp_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .rd_valid(rd_valid), .rd_data(rd_data), .array_go(array_go),
    .array_req(array_req), .status(status), .pe_ready(pe_ready),
    .prot_err(prot_err), .cmd_refused(cmd_refused)
);

// *** verification/sbp_host_model.sv ***
// Host controller model: issues decoded commands, drives the protect pin.
// Assumes the bench calls send() and sets wp_level.
`timescale 1ns/100ps
module sbp_host_model
    import sbp_pkg::*;
(
    // Clock
    input wire logic         clk,
    // Toward the core
    output logic             cmd_valid,
    output sbp_pkg::sbp_cmd_t cmd,
    output logic             wp_n
);
    logic wp_level = 1'b1;
    initial begin
        cmd_valid = 1'b0;
        cmd       = '0;
        wp_n      = 1'b1;
    end
    // No pull-up on the pin, so it is driven at every rising clock edge
    always @(posedge clk) wp_n <= wp_level;

    // One-cycle command pulse; write enable precedes writes
    task automatic send(input sbp_op_t op, input logic [23:0] a, input logic [7:0] d);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd       <= '{op: op, addr: a, wdata: d};
        @(posedge clk);
        cmd_valid <= 1'b0;
        // Stale fields scrambled so nobody trusts them after release
        cmd       <= ~cmd;
    endtask
endmodule // sbp_host_model

// *** verification/sbp_status_protect_tb_top.sv ***
// Self-checking bench for the status and block-protection core.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module sbp_status_protect_tb_top;
    import sbp_pkg::*;
    logic           clk, rstn, wp_n, cmd_valid, rd_valid, array_go;
    logic           pe_ready, prot_err, cmd_refused;
    logic [7:0]     rd_data, status;
    sbp_cmd_t       cmd;
    sbp_array_req_t array_req;
    int             n_errors = 0, n_tests = 0, cycles = 0;

    sbp_host_model u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .wp_n(wp_n));
    // Short busy times keep the decode sweep quick
    sbp_status_protect #(.WRSR_CYC(4), .PROG_CYC(4), .ERASE_CYC(4)) u_dut (
        .clk(clk), .rstn(rstn), .wp_n(wp_n), .cmd_valid(cmd_valid), .cmd(cmd),
        .rd_valid(rd_valid), .rd_data(rd_data), .array_go(array_go),
        .array_req(array_req), .status(status), .pe_ready(pe_ready),
        .prot_err(prot_err), .cmd_refused(cmd_refused));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic go(sbp_op_t op, logic [23:0] a = 24'h0, logic [7:0] d = 8'h0);
        u_host.send(op, a, d);
        #1;
    endtask
    task automatic wait_idle();
        for (int k = 0; k < 400 && pe_ready !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        `CHK("idle", 1'b1, pe_ready)
    endtask
    task automatic set_sr(logic [7:0] v);
        go(SBP_OP_WR_EN);
        go(SBP_OP_WRITE_SR, 24'h0, v);
        wait_idle();
    endtask
    task automatic probe(sbp_op_t op, logic [7:0] s, logic p);
        go(SBP_OP_WR_EN);
        go(op, {s, 16'h0});
        `CHK("prot_err", p, prot_err)
        `CHK("array_go", !p, array_go)
        // Accepted request must carry the command's own op and address
        if (!p) begin
            `CHK("req_op", op, array_req.op)
            `CHK("req_addr", {s, 16'h0}, array_req.addr)
        end
        wait_idle();
    endtask

    task automatic t_reset_wel();
        `CHK("status", 8'h00, status)
        `CHK("pe_ready", 1'b1, pe_ready)
        go(SBP_OP_PROGRAM);
        `CHK("refused", 1'b1, cmd_refused)
        go(SBP_OP_WR_EN);
        `CHK("wel", 1'b1, status[1])
        go(SBP_OP_WR_DIS);
        `CHK("wel", 1'b0, status[1])
    endtask
    task automatic t_wrsr();
        go(SBP_OP_WR_EN);
        go(SBP_OP_WRITE_SR, 24'h0, 8'h1c);
        `CHK("wip", 1'b1, status[0])
        go(SBP_OP_WR_EN);
        `CHK("busy refused", 1'b1, cmd_refused)
        wait_idle();
        go(SBP_OP_READ_SR);
        `CHK("rd_valid", 1'b1, rd_valid)
        `CHK("rd_data", 8'h1c, rd_data)
    endtask
    task automatic t_decode();
        logic [8:0] cnt;
        sbp_op_t    op;
        for (int t = 0; t < 2; t++) begin
            for (int n = 0; n < 16; n++) begin
                cnt = (n == 0) ? 9'h0 : (n > 8) ? 9'h100 : 9'(9'h1 << (n - 1));
                set_sr({1'b0, n[3], t[0], n[2:0], 2'b00});
                op = sbp_op_t'(3'(4 + n % 3));
                if (cnt != 0) probe(op, 8'(t ? cnt - 1 : 256 - cnt), 1'b1);
                if (cnt != 256) probe(op, 8'(t ? cnt : 255 - cnt), 1'b0);
                probe(SBP_OP_BULK_ER, 8'h0, n != 0);
            end
        end
    endtask
    task automatic t_hwp();
        set_sr(8'h80);
        u_host.wp_level <= 1'b0;
        repeat (3) @(posedge clk);
        go(SBP_OP_WR_EN);
        go(SBP_OP_WRITE_SR, 24'h0, 8'h00);
        `CHK("locked", 1'b1, cmd_refused)
        `CHK("status", 8'h80, status)
        u_host.wp_level <= 1'b1;
        repeat (3) @(posedge clk);
        set_sr(8'h00);
        `CHK("status", 8'h00, status)
    endtask

    initial begin
        rstn = 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        #1;
        t_reset_wel();
        t_wrsr();
        t_decode();
        t_hwp();
        tally_and_finish();
    end
endmodule // sbp_status_protect_tb_top
